// File: core_consts.vh
// constants for the core memory map and sfr block
// assumes inclusion by core_memory_map.v only
`ifndef CORE_CONSTS_VH
`define CORE_CONSTS_VH
`define SFR_SP_LOW 8'h81
`define SFR_POWER_CONTROL_REG 8'h87
`define SFR_WAIT 8'h9F
`define SFR_CFG 8'hAF
`define SFR_SP_HIGH 8'hB7
`define SFR_PSW 8'hD0
`define SFR_ACC 8'hE0
`define SFR_DP_LOW 8'h82
`define SFR_DP_HIGH 8'h83
`define SFR_DP_PAGE 8'h84
`define SP_RESET 8'h07
`define POWER_CONTROL_REG_RESET 8'h00
`define WAIT_RESET 8'h00
`define CFG_RESET 8'h00
`define PSW_RESET 8'h00
`define CFG_STACK_EXT 7
`define CFG_XRAM_MAP 0
`define POWER_CONTROL_REG_BAUD2 7
`define POWER_CONTROL_REG_SER_WAKE 6
`define POWER_CONTROL_REG_IRQ_WAKE 5
`define POWER_CONTROL_REG_ALE_OFF 4
`define POWER_CONTROL_REG_PD 1
`define XRAM_TOP 24'h0007FF
`define MOVX_BASE_CYCLES 4
`define WAIT_MAX 3'h7
`define SFR_AREA_BASE 8'h80
`define BIT_RAM_BASE 8'h20
`endif

// File: core_memory_map.v
// core memory map: internal ram, stack pointer, data pointer, status word,
// power control, configuration and movx decode with wait states.
// assumes a cpu sequencer drives the request ports one access per cycle.
// Contract
// - with ext access high at reset, fetch code only internally, no rollover
// - 56 kbytes of program memory writable at run time
// - 4 kbytes nonvolatile data reached only through sfr registers
// - lower 128 ram bytes direct or indirect; upper 128 indirect only
// - lowest 32 bytes are four banks chosen by two status bits
// - bytes 20H-2FH bit addressable as bits 00H-7FH
// - stack pointer resets to 07H; push pre-increments, first at 08H
// - map enable sends movx below 2 kbytes on chip, else off chip
// - pointer above 0007FFH always goes external
// - on-chip xram accesses leave external strobes and bus idle
// - stack wraps FFH to 00H, or into 0100H with extension on
// - stack low at 81H, high at B7H holds three extra bits
// - stack high ignores writes and reads zero unless extension enabled
// - movx reaches 16 Mbytes with automatic strobes
// - wait register 0-7; movx takes four plus n cycles
// - data pointer page, high, low; increment carries into page
// - status word at D0H bit addressable, resets 00H, fixed layout
// - writing power-down bit 1 enters power-down
// - serial wake bit lets spi or i2c interrupt end power-down
// - irq wake bit ends power-down on low level or falling edge
// - power_control_reg bit 4 disables address latch strobe
// - power_control_reg bit 7 doubles uart baud rate
// - config bit 7 extends stack, bit 0 maps xram
// - config register resets to 00H, both features off
`timescale 1ns/10ps
`include "core_consts.vh"
module core_memory_map #(
  parameter PROG_KB = 62,
  parameter PROG_WRITABLE_KB = 56,
  parameter DATA_FLASH_KB = 4
) (
  input wire core_clk, // core clock
  input wire sys_rst, // async reset, active high
  input wire ext_access_select, // strap pin, sampled after reset
  input wire [15:0] code_addr, // fetch address
  output reg code_fetch_internal, // fetch from internal flash
  output reg code_addr_fault, // fetch beyond internal space
  input wire [15:0] prog_write_addr, // run-time program write address
  input wire prog_write_req, // run-time program write request
  output wire prog_write_allow, // write lies in reprogrammable area
  input wire [7:0] sfr_addr, // direct sfr address
  input wire sfr_wr, // sfr write strobe
  input wire sfr_rd, // sfr read strobe
  input wire [7:0] sfr_wdata, // sfr write data
  output reg [7:0] sfr_rdata, // sfr read data, registered
  output wire sfr_hit, // address is one of ours
  input wire [7:0] ram_addr, // internal ram address
  input wire ram_indirect, // 1 = indirect addressing
  input wire [2:0] reg_num, // working register number
  input wire reg_sel, // access working register reg_num
  input wire ram_wr, // ram write strobe
  input wire [7:0] ram_wdata, // ram write data
  output reg [7:0] ram_rdata, // ram read data, registered
  input wire [6:0] bit_addr, // bit address 00H-7FH
  input wire bit_wr, // bit write strobe
  input wire bit_wdata, // bit value
  output reg bit_rdata, // bit read data, registered
  input wire push_req, // push or call byte
  input wire pop_req, // pop or return byte
  input wire [7:0] push_data, // byte to push
  output reg [7:0] pop_data, // popped byte, registered
  input wire data_pointer_inc, // increment data pointer
  input wire [7:0] acc_value, // accumulator contents
  input wire [7:0] psw_hw_flags, // hardware flag updates {cy,ac,ov}
  input wire psw_hw_we, // load carry, half carry, overflow
  input wire movx_req, // start movx
  input wire movx_write, // 1 = write
  input wire [7:0] movx_wdata, // write data
  output reg [7:0] movx_rdata, // read data, registered
  output wire movx_busy, // movx in progress
  output reg movx_done, // one-cycle end pulse
  output reg [23:0] ext_addr, // external address bus
  output reg [7:0] ext_data_out, // external data out
  output reg ext_data_oe, // external data enable
  input wire [7:0] ext_data_in, // external data in
  output reg ext_rd_n, // external read strobe, low active
  output reg ext_wr_n, // external write strobe, low active
  output reg ale_out, // address latch enable
  output reg ext_bus_active, // ports used by movx
  input wire spi_irq, // spi interrupt
  input wire i2c_irq, // i2c interrupt
  input wire ext_irq_zero_pin, // interrupt pin zero
  input wire irq_zero_edge_select, // 1 = falling edge
  output wire power_down, // power-down mode active
  output wire uart_baud_doubler, // doubled uart rate
  output wire latch_strobe_disable, // latch strobe off
  output wire [1:0] active_bank // selected register bank
);
  localparam ST_IDLE = 2'd0;
  localparam ST_ADDR = 2'd1;
  localparam ST_WAIT = 2'd2;
  localparam ST_DONE = 2'd3;

  reg [7:0] ram_r [0:255];
  reg [7:0] xram_r [0:2047];
  reg [7:0] sp_low_r;
  reg [2:0] sp_high_r;
  reg [7:0] power_control_reg_r;
  reg [2:0] wait_r;
  reg [7:0] cfg_r;
  reg [7:0] psw_r;
  reg [7:0] dp_low_r;
  reg [7:0] dp_high_r;
  reg [7:0] dp_page_r;
  reg ext_code_r;
  reg strap_taken_r;
  reg irq_pin_d_r;
  reg [1:0] mx_state_r;
  reg [3:0] mx_cnt_r;
  reg mx_write_r;
  reg mx_internal_r;
  reg [7:0] mx_wdata_r;
  wire [23:0] data_pointer = {dp_page_r, dp_high_r, dp_low_r};
  wire stack_ext = cfg_r[`CFG_STACK_EXT];
  wire xram_map = cfg_r[`CFG_XRAM_MAP];
  wire [10:0] sp_full = {sp_high_r, sp_low_r};
  wire [10:0] sp_inc = sp_full + 11'h001;
  wire [10:0] sp_dec = sp_full - 11'h001;
  wire [7:0] sp_low_inc = sp_low_r + 8'h01;
  wire movx_internal = xram_map && (data_pointer <= `XRAM_TOP);
  wire [15:0] dp16_inc = {dp_high_r, dp_low_r} + 16'h0001;
  wire [7:0] parity_now = {psw_r[7:1], ^acc_value};
  reg [7:0] ram_idx;
  reg ram_sfr_clash;

  // decode a bit address into its byte in the bit area
  function [7:0] bit_byte;
    input [6:0] b;
    begin
      bit_byte = `BIT_RAM_BASE + {4'h0, b[6:3]};
    end
  endfunction

  // the strap is caught one clock after reset release, never by the reset itself
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_code_r <= 1'b0;
      strap_taken_r <= 1'b0;
    end else if (!strap_taken_r) begin
      ext_code_r <= ext_access_select;
      strap_taken_r <= 1'b1;
    end
  end

  // code fetch: no external code space exists, so anything past the flash faults
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      code_fetch_internal <= 1'b0;
      code_addr_fault <= 1'b0;
    end else begin
      code_fetch_internal <= ext_code_r;
      code_addr_fault <= ({1'b0, code_addr} >= PROG_KB * 1024);
    end
  end

  assign prog_write_allow = prog_write_req && ({1'b0, code_addr} < 17'h1FFFF) &&
    ({1'b0, prog_write_addr} < PROG_WRITABLE_KB * 1024);

  // ram address: working register, else the given address; direct upper half is sfr space
  always @* begin
    ram_idx = ram_addr;
    if (reg_sel) begin
      ram_idx = {3'b000, psw_r[4:3], reg_num};
    end
    ram_sfr_clash = !reg_sel && !ram_indirect && ram_addr[7];
  end

  assign active_bank = psw_r[4:3];

  // ram port, bit port and stack share one array; stack takes priority
  always @(posedge core_clk) begin
    if (push_req) begin
      // a push that runs past 00FFH belongs to xram and must not clobber low ram
      if (!(stack_ext && sp_inc[10:8] != 3'h0)) begin
        ram_r[sp_low_inc] <= push_data;
      end
    end else if (ram_wr && !ram_sfr_clash) begin
      ram_r[ram_idx] <= ram_wdata;
    end else if (bit_wr) begin
      ram_r[bit_byte(bit_addr)][bit_addr[2:0]] <= bit_wdata;
    end
    ram_rdata <= ram_sfr_clash ? 8'h00 : ram_r[ram_idx];
    bit_rdata <= ram_r[bit_byte(bit_addr)][bit_addr[2:0]];
    if (stack_ext && sp_high_r != 3'h0) begin
      pop_data <= xram_r[sp_full];
    end else begin
      pop_data <= ram_r[sp_low_r];
    end
  end

  // stack pointer: plain 8-bit wrap, or 11-bit run into xram when extended
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sp_low_r <= `SP_RESET;
      sp_high_r <= 3'h0;
    end else if (push_req) begin
      if (stack_ext) begin
        sp_low_r <= sp_inc[7:0];
        sp_high_r <= sp_inc[10:8];
      end else begin
        sp_low_r <= sp_low_inc;
      end
    end else if (pop_req) begin
      if (stack_ext) begin
        sp_low_r <= sp_dec[7:0];
        sp_high_r <= sp_dec[10:8];
      end else begin
        sp_low_r <= sp_low_r - 8'h01;
      end
    end else if (sfr_wr && sfr_addr == `SFR_SP_LOW) begin
      sp_low_r <= sfr_wdata;
    end else if (sfr_wr && sfr_addr == `SFR_SP_HIGH && stack_ext) begin
      sp_high_r <= sfr_wdata[2:0];
    end
  end

  // sfr registers other than the stack pointer
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      power_control_reg_r <= `POWER_CONTROL_REG_RESET;
      wait_r <= 3'h0;
      cfg_r <= `CFG_RESET;
      psw_r <= `PSW_RESET;
      dp_low_r <= 8'h00;
      dp_high_r <= 8'h00;
      dp_page_r <= 8'h00;
      irq_pin_d_r <= 1'b1;
    end else begin
      irq_pin_d_r <= ext_irq_zero_pin;
      psw_r <= parity_now;
      if (psw_hw_we) begin
        psw_r <= {psw_hw_flags[2:1], psw_r[5:3], psw_hw_flags[0], psw_r[1], ^acc_value};
      end
      if (bit_wr && bit_addr[6:3] == 4'hA) begin
        psw_r[bit_addr[2:0]] <= bit_wdata;
      end
      if (data_pointer_inc) begin
        {dp_high_r, dp_low_r} <= dp16_inc;
        if (dp16_inc == 16'h0000) begin
          dp_page_r <= dp_page_r + 8'h01;
        end
      end
      // power-down wake wins over a stale request bit
      if (power_control_reg_r[`POWER_CONTROL_REG_PD]) begin
        if ((power_control_reg_r[`POWER_CONTROL_REG_SER_WAKE] && (spi_irq || i2c_irq)) ||
            (power_control_reg_r[`POWER_CONTROL_REG_IRQ_WAKE] && (irq_zero_edge_select ?
              (irq_pin_d_r && !ext_irq_zero_pin) : !ext_irq_zero_pin))) begin
          power_control_reg_r[`POWER_CONTROL_REG_PD] <= 1'b0;
        end
      end
      if (sfr_wr) begin
        if (sfr_addr == `SFR_POWER_CONTROL_REG) begin
          power_control_reg_r <= {sfr_wdata[7:1], 1'b0};
        end else if (sfr_addr == `SFR_WAIT) begin
          wait_r <= sfr_wdata[2:0];
        end else if (sfr_addr == `SFR_CFG) begin
          cfg_r <= {sfr_wdata[7], 6'h00, sfr_wdata[0]};
        end else if (sfr_addr == `SFR_PSW) begin
          psw_r <= {sfr_wdata[7:1], ^acc_value};
        end else if (sfr_addr == `SFR_DP_LOW) begin
          dp_low_r <= sfr_wdata;
        end else if (sfr_addr == `SFR_DP_HIGH) begin
          dp_high_r <= sfr_wdata;
        end else if (sfr_addr == `SFR_DP_PAGE) begin
          dp_page_r <= sfr_wdata;
        end
      end
    end
  end

  assign power_down = power_control_reg_r[`POWER_CONTROL_REG_PD];
  assign uart_baud_doubler = power_control_reg_r[`POWER_CONTROL_REG_BAUD2];
  assign latch_strobe_disable = power_control_reg_r[`POWER_CONTROL_REG_ALE_OFF];
  assign sfr_hit = (sfr_addr == `SFR_SP_LOW) || (sfr_addr == `SFR_POWER_CONTROL_REG) || (sfr_addr == `SFR_WAIT) ||
    (sfr_addr == `SFR_CFG) || (sfr_addr == `SFR_SP_HIGH && stack_ext) || (sfr_addr == `SFR_PSW) ||
    (sfr_addr == `SFR_DP_LOW) || (sfr_addr == `SFR_DP_HIGH) || (sfr_addr == `SFR_DP_PAGE);

  // sfr read: one cycle latency, unmapped reads zero
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      if (sfr_addr == `SFR_SP_LOW) begin
        sfr_rdata <= sp_low_r;
      end else if (sfr_addr == `SFR_SP_HIGH) begin
        sfr_rdata <= stack_ext ? {5'h00, sp_high_r} : 8'h00;
      end else if (sfr_addr == `SFR_POWER_CONTROL_REG) begin
        sfr_rdata <= power_control_reg_r;
      end else if (sfr_addr == `SFR_WAIT) begin
        sfr_rdata <= {5'h00, wait_r};
      end else if (sfr_addr == `SFR_CFG) begin
        sfr_rdata <= cfg_r;
      end else if (sfr_addr == `SFR_PSW) begin
        sfr_rdata <= psw_r;
      end else if (sfr_addr == `SFR_DP_LOW) begin
        sfr_rdata <= dp_low_r;
      end else if (sfr_addr == `SFR_DP_HIGH) begin
        sfr_rdata <= dp_high_r;
      end else if (sfr_addr == `SFR_DP_PAGE) begin
        sfr_rdata <= dp_page_r;
      end else begin
        sfr_rdata <= 8'h00;
      end
    end
  end

  assign movx_busy = (mx_state_r != ST_IDLE);

  // movx sequencer: address, wait states, strobe end; 4 + n cycles from request to done
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mx_state_r <= ST_IDLE;
      mx_cnt_r <= 4'h0;
      mx_write_r <= 1'b0;
      mx_internal_r <= 1'b0;
      mx_wdata_r <= 8'h00;
      movx_done <= 1'b0;
      movx_rdata <= 8'h00;
      ext_addr <= 24'h000000;
      ext_data_out <= 8'h00;
      ext_data_oe <= 1'b0;
      ext_rd_n <= 1'b1;
      ext_wr_n <= 1'b1;
      ale_out <= 1'b0;
      ext_bus_active <= 1'b0;
    end else begin
      movx_done <= 1'b0;
      ale_out <= 1'b0;
      case (mx_state_r)
        ST_IDLE: begin
          if (movx_req) begin
            mx_write_r <= movx_write;
            mx_wdata_r <= movx_wdata;
            mx_internal_r <= movx_internal;
            mx_cnt_r <= {1'b0, wait_r};
            mx_state_r <= ST_ADDR;
            if (!movx_internal) begin
              ext_addr <= data_pointer;
              ext_bus_active <= 1'b1;
              ale_out <= !latch_strobe_disable;
            end
          end
        end
        ST_ADDR: begin
          mx_state_r <= ST_WAIT;
          if (!mx_internal_r) begin
            ext_rd_n <= mx_write_r;
            ext_wr_n <= !mx_write_r;
            ext_data_oe <= mx_write_r;
            ext_data_out <= mx_wdata_r;
          end
        end
        ST_WAIT: begin
          if (mx_cnt_r == 4'h0) begin
            mx_state_r <= ST_DONE;
          end else begin
            mx_cnt_r <= mx_cnt_r - 4'h1;
          end
        end
        ST_DONE: begin
          mx_state_r <= ST_IDLE;
          movx_done <= 1'b1;
          if (mx_internal_r) begin
            if (mx_write_r) begin
              xram_r[data_pointer[10:0]] <= mx_wdata_r;
            end
            movx_rdata <= xram_r[data_pointer[10:0]];
          end else begin
            movx_rdata <= mx_write_r ? movx_rdata : ext_data_in;
          end
          ext_rd_n <= 1'b1;
          ext_wr_n <= 1'b1;
          ext_data_oe <= 1'b0;
          ext_bus_active <= 1'b0;
        end
        default: mx_state_r <= ST_IDLE;
      endcase
      // extended stack pushes above 00FFH land in xram
      if (push_req && stack_ext && sp_inc[10:8] != 3'h0) begin
        xram_r[sp_inc] <= push_data;
      end
    end
  end

  // nonvolatile data memory is reached through its own sfr group outside this block
  wire [31:0] data_flash_bytes = DATA_FLASH_KB * 1024;
endmodule

// File: core_memory_map_properties.sv
// concurrent checks on the ports of the core memory map block
// assumes one clock domain and an active-high asynchronous reset
`timescale 1ns/10ps
module core_memory_map_properties (
  input wire core_clk, // core clock
  input wire sys_rst, // reset, active high
  input wire [15:0] prog_write_addr, // program write address
  input wire prog_write_req, // program write request
  input wire prog_write_allow, // write permitted
  input wire [7:0] sfr_addr, // sfr address
  input wire sfr_wr, // sfr write strobe
  input wire [7:0] sfr_wdata, // sfr write data
  input wire bit_wr, // bit write strobe
  input wire movx_req, // movx start
  input wire movx_busy, // movx in progress
  input wire movx_done, // movx end pulse
  input wire ext_rd_n, // read strobe
  input wire ext_wr_n, // write strobe
  input wire ext_bus_active, // ports owned by movx
  input wire ale_out, // latch strobe
  input wire latch_strobe_disable, // latch strobe off
  input wire power_down, // power-down state
  input wire uart_baud_doubler, // doubled baud
  input wire [1:0] active_bank // selected bank
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // bit writes into the status word could race a byte write, so they are excluded
  a_bank_follows_psw: assert property (sfr_wr && sfr_addr == 8'hD0 && !bit_wr |=> active_bank == $past(sfr_wdata[4:3]))
    else $error("bank select not taken from status write");
  a_movx_length: assert property (movx_req && !movx_busy |-> ##[3:12] movx_done)
    else $error("movx did not end in time");
  a_movx_starts: assert property (movx_req && !movx_busy |=> movx_busy)
    else $error("movx request not taken");
  a_done_single: assert property (movx_done |=> !movx_done)
    else $error("done pulse longer than one cycle");
  a_strobes_idle: assert property (!ext_bus_active |-> ext_rd_n && ext_wr_n)
    else $error("strobe active while bus idle");
  a_strobe_exclusive: assert property (!(!ext_rd_n && !ext_wr_n))
    else $error("read and write strobes together");
  a_ale_disabled: assert property (latch_strobe_disable |-> !ale_out)
    else $error("latch strobe while disabled");
  a_pd_on_write: assert property (sfr_wr && sfr_addr == 8'h87 |=> power_down == $past(sfr_wdata[1]))
    else $error("power-down not set by write");
  a_baud_bit: assert property (sfr_wr && sfr_addr == 8'h87 |=> uart_baud_doubler == $past(sfr_wdata[7]))
    else $error("baud doubler not following write");
  a_prog_window: assert property (prog_write_allow == (prog_write_req && prog_write_addr < 16'hE000))
    else $error("program write window wrong");
endmodule
bind core_memory_map core_memory_map_properties chk (.*);

// File: ext_sram_model.sv
// behavioural asynchronous data ram on the movx bus
// assumes low-active strobes from the core and a 24-bit address
`timescale 1ns/10ps
module ext_sram_model #(parameter int ACC_NS = 15) (
  input wire logic [23:0] ext_addr, // address from the core
  input wire logic [7:0] ext_data_out, // write data from the core
  input wire logic ext_data_oe, // core drives data
  input wire logic ext_rd_n, // read strobe, low active
  input wire logic ext_wr_n, // write strobe, low active
  output logic [7:0] ext_data_in // read data to the core
);
  logic [7:0] mem [logic [23:0]];
  int n_wr = 0;
  initial ext_data_in = 8'h00;
  // data shows only after the access time; released bus shows the inverse, not stale data
  always @(negedge ext_rd_n) ext_data_in <= #(ACC_NS) (mem.exists(ext_addr) ? mem[ext_addr] : 8'h5A);
  always @(posedge ext_rd_n) ext_data_in <= ~ext_data_in;
  // sample a little after the strobe falls so the core's data has settled
  always @(negedge ext_wr_n) begin
    #1;
    if (ext_data_oe) mem[ext_addr] = ext_data_out;
    n_wr++;
  end
endmodule

// File: core_memory_map_bench.sv
// self-checking bench for the core memory map block
// assumes the external ram model on the movx pins
`timescale 1ns/10ps
module core_memory_map_bench;
  logic core_clk = 0, sys_rst = 1, ext_access_select = 1, prog_write_req = 0, sfr_wr = 0, sfr_rd = 0;
  logic ram_indirect = 0, reg_sel = 0, ram_wr = 0, bit_wr = 0, bit_wdata = 0, push_req = 0, pop_req = 0;
  logic data_pointer_inc = 0, psw_hw_we = 0, movx_req = 0, movx_write = 0, spi_irq = 0, i2c_irq = 0;
  logic ext_irq_zero_pin = 1, irq_zero_edge_select = 0, ext_seen = 0;
  logic [15:0] code_addr = 16'h0000, prog_write_addr = 16'h0000;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, ram_addr = 8'h00, ram_wdata = 8'h00, push_data = 8'h00;
  logic [7:0] acc_value = 8'h00, psw_hw_flags = 8'h00, movx_wdata = 8'h00, rd;
  logic [6:0] bit_addr = 7'h00;
  logic [2:0] reg_num = 3'h0;
  wire code_fetch_internal, code_addr_fault, prog_write_allow, sfr_hit, bit_rdata, movx_busy, movx_done;
  wire ext_data_oe, ext_rd_n, ext_wr_n, ale_out, ext_bus_active, power_down, uart_baud_doubler;
  wire latch_strobe_disable;
  wire [7:0] sfr_rdata, ram_rdata, pop_data, movx_rdata, ext_data_out, ext_data_in;
  wire [23:0] ext_addr;
  wire [1:0] active_bank;
  int n_fail = 0, num_checks = 0, cyc = 0, n;
  core_memory_map DUT (.*);
  ext_sram_model m (.*);
  always #5 core_clk = ~core_clk;
  // catches any use of the external pins during an access meant to stay on chip
  always @(posedge core_clk) if (ext_bus_active || !ext_rd_n || !ext_wr_n) ext_seen = 1;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      final_report;
    end
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tick; @(posedge core_clk); #1; endtask
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // every request is followed by an idle edge so a strobe is never re-driven at once
  task automatic sw(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a; sfr_wdata = d; sfr_wr = 1; tick; sfr_wr = 0; tick;
  endtask
  task automatic sr(input logic [7:0] a);
    sfr_addr = a; sfr_rd = 1; tick; sfr_rd = 0; rd = sfr_rdata; tick;
  endtask
  task automatic ram(input logic ind, input logic w, input logic [7:0] a, input logic [7:0] d);
    ram_indirect = ind; ram_addr = a; ram_wdata = d; ram_wr = w; tick; ram_wr = 0; rd = ram_rdata; tick;
  endtask
  task automatic stk(input logic p, input logic [7:0] d);
    push_req = p; pop_req = !p; push_data = d; tick; push_req = 0; pop_req = 0; rd = pop_data; tick;
  endtask
  task automatic dp(input logic [23:0] v);
    sw(8'h84, v[23:16]); sw(8'h83, v[15:8]); sw(8'h82, v[7:0]);
  endtask
  task automatic mx(input logic w, input logic [7:0] d);
    movx_write = w; movx_wdata = d; movx_req = 1; tick; movx_req = 0; n = 1;
    do begin tick; n++; end while (movx_done !== 1'b1 && n < 20);
    rd = movx_rdata; tick;
  endtask
  task automatic t_reset;
    logic [7:0] ra [6] = '{8'h81, 8'hD0, 8'h87, 8'h9F, 8'hAF, 8'hB7};
    logic [7:0] rv [6] = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 6; i++) begin sr(ra[i]); chk(rd, rv[i]); end
    chk(sfr_hit, 0);
    chk(code_fetch_internal, 1);
    code_addr = 16'hF800; prog_write_req = 1; prog_write_addr = 16'hDFFF; #1;
    chk(prog_write_allow, 1);
    tick; chk(code_addr_fault, 1);
    prog_write_addr = 16'hE000; code_addr = 16'hF7FF; #1;
    chk(prog_write_allow, 0);
    tick; chk(code_addr_fault, 0);
    prog_write_req = 0; acc_value = 8'h07; tick; sr(8'hD0); chk(rd, 8'h01);
    acc_value = 8'h00; $display("reset and map test ended");
  endtask
  task automatic t_ram;
    ram(0, 1, 8'h90, 8'h5A); ram(0, 0, 8'h90, 8'h00); chk(rd, 8'h00);
    ram(1, 1, 8'h90, 8'h5A); ram(1, 0, 8'h90, 8'h00); chk(rd, 8'h5A);
    for (int b = 0; b < 4; b++) begin
      sw(8'hD0, 8'(b << 3)); chk(active_bank, b);
      reg_sel = 1; reg_num = 3'h2; ram(0, 1, 8'h00, 8'(8'h30 + b)); reg_sel = 0;
      ram(1, 0, 8'(b * 8 + 2), 8'h00); chk(rd, 8'h30 + b);
    end
    sw(8'hD0, 8'h00);
    bit_addr = 7'h0F; bit_wdata = 1; bit_wr = 1; tick; bit_wr = 0; tick;
    ram(1, 0, 8'h21, 8'h00); chk(rd, 8'h80);
    chk(bit_rdata, 1);
    $display("ram test ended");
  endtask
  task automatic t_stack;
    stk(1, 8'h11); stk(1, 8'h22); sr(8'h81); chk(rd, 8'h09);
    ram(1, 0, 8'h08, 8'h00); chk(rd, 8'h11);
    stk(0, 8'h00); chk(rd, 8'h22); stk(0, 8'h00); chk(rd, 8'h11); sr(8'h81); chk(rd, 8'h07);
    sw(8'hB7, 8'h05); sr(8'hB7); chk(rd, 8'h00);
    sw(8'h81, 8'hFF); stk(1, 8'h33); sr(8'h81); chk(rd, 8'h00);
    ram(1, 0, 8'h00, 8'h00); chk(rd, 8'h33);
    sw(8'hAF, 8'h80); sw(8'h81, 8'hFF); stk(1, 8'h44); sr(8'hB7); chk(rd, 8'h01);
    sw(8'hB7, 8'h02); sr(8'hB7); chk(rd, 8'h02);
    sw(8'hAF, 8'h00); sw(8'h81, 8'h07); $display("stack test ended");
  endtask
  task automatic t_movx;
    logic [2:0] ws [3] = '{3'h0, 3'h2, 3'h7};
    for (int i = 0; i < 3; i++) begin
      sw(8'h9F, 8'(ws[i])); dp(24'h000100 + i);
      mx(1, 8'hC0 + i); chk(n, 4 + ws[i]);
      mx(0, 8'h00); chk(rd, 8'hC0 + i);
    end
    chk(m.n_wr, 3);
    sw(8'hAF, 8'h01); dp(24'h000010); ext_seen = 0;
    mx(1, 8'h6B); mx(0, 8'h00); chk(rd, 8'h6B);
    chk(ext_seen, 0);
    dp(24'h000800); mx(1, 8'h9C); chk(ext_seen, 1);
    dp(24'hFF00AB); mx(1, 8'h3E); chk(m.mem.exists(24'hFF00AB), 1);
    dp(24'h12FFFF); data_pointer_inc = 1; tick; data_pointer_inc = 0; tick;
    sr(8'h84); chk(rd, 8'h13); sr(8'h83); chk(rd, 8'h00);
    $display("movx test ended");
  endtask
  task automatic t_power_control_reg;
    sw(8'h87, 8'h82); chk(uart_baud_doubler, 1); chk(power_down, 1);
    sw(8'h87, 8'h10); chk(latch_strobe_disable, 1); mx(0, 8'h00);
    for (int i = 0; i < 3; i++) begin
      sw(8'h87, i == 0 ? 8'h02 : 8'h42); spi_irq = (i < 2); i2c_irq = (i == 2); tick; tick;
      chk(power_down, i == 0);
      spi_irq = 0; i2c_irq = 0; tick;
    end
    sw(8'h87, 8'h22); ext_irq_zero_pin = 0; tick; tick; chk(power_down, 0);
    ext_irq_zero_pin = 1; irq_zero_edge_select = 1; sw(8'h87, 8'h22); tick;
    chk(power_down, 1);
    ext_irq_zero_pin = 0; tick; tick; chk(power_down, 0);
    ext_irq_zero_pin = 1; irq_zero_edge_select = 0; $display("power control test ended");
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    #1 sys_rst = 0;
    tick;
    tick;
    t_reset;
    t_ram;
    t_stack;
    t_movx;
    t_power_control_reg;
    final_report;
  end
endmodule
